//--- logic/pxb_crossbar.sv
// Priority pin crossbar with its register two and the port 0 data register
`timescale 1ns/10ps
module pxb_crossbar import pxb_pkg::*; #(
	// Pins on the package: 32 on the larger one, 24 on the smaller
	parameter int NUM_PINS = PINS_LARGE
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Special function register access
	input wire pxb_sfr_req_type sfrReq,
	output logic [7:0] sfrRdata,
	// Configuration registers held outside this block
	input wire logic [7:0] crossbarConfigZero,
	input wire logic [7:0] crossbarConfigOne,
	input wire logic [7:0] crossbarConfigThree,
	// Peripheral side, one bit per slot in priority order
	input wire logic [NUM_SLOTS-1:0] periphOut,
	input wire logic [NUM_SLOTS-1:0] periphDrive,
	output logic [NUM_SLOTS-1:0] periphIn,
	output logic [NUM_SLOTS-1:0] periphPinned,
	// Port pins, ports 0 upward
	input wire logic [NUM_PINS-1:0] pinIn,
	output logic [NUM_PINS-1:0] pinOut,
	output logic [NUM_PINS-1:0] pinOe,
	// Global pull-up disable for the pad ring
	output logic weakPullupOff
);
	// Pin index width; one spare code so that a slot pushed past the
	// last pin shows an index that no real pin has
	localparam int IDX_W = $clog2(NUM_SLOTS + 1);

	// Register state
	logic [7:0] crossbarConfigTwo_r; // Configuration register two
	logic [7:0] port0Latch_r; // Port 0 output latch
	// Pin levels after the synchroniser
	logic [NUM_PINS-1:0] pinSync; // Synchronised pin levels
	// Routing decode
	logic [NUM_SLOTS-1:0] slotEn; // Slots requesting a pin
	logic [IDX_W-1:0] slotPin [NUM_SLOTS]; // Pin index per slot
	// Next values of the registered pin and peripheral outputs
	logic [NUM_PINS-1:0] pinOut_nxt; // Level offered to each pad
	logic [NUM_PINS-1:0] pinOe_nxt; // Pad driven by the block
	logic [NUM_SLOTS-1:0] periphIn_nxt; // Level handed to each slot
	// Control decode
	logic globalEn; // Crossbar enable bit of register two
	logic cfg2Hit; // Request addresses configuration register two
	logic port0Hit; // Request addresses the port 0 register, any page

	// Pin levels pass two flops before any logic reads them; the pads
	// change with no relation to sys_clk, so a single flop could go
	// metastable and hand two readers two different levels
	pxb_pin_sync #(.WIDTH(NUM_PINS)) pinSyncInst (
		.sys_clk(sys_clk),
		.reset(reset),
		.asyncIn(pinIn),
		.syncOut(pinSync)
	);

	// Turns a peripheral count into a thermometer of slot enables.
	// The capture module count asks for that many output pins, lowest
	// output first; a count above the number of outputs saturates
	function automatic logic [PCA_MAX-1:0] thermo(input logic [2:0] cnt);
		logic [PCA_MAX-1:0] t;
		// All outputs off, then one on for each counted output
		t = '0;
		for (int i = 0; i < PCA_MAX; i++) begin
			t[i] = (32'(cnt) > i);
		end
		return t;
	endfunction

	// Register decode. Register two sits on one page only, while the
	// port 0 register answers on every page
	assign cfg2Hit = (sfrReq.addr == CROSSBAR_CONFIG_TWO_ADDR) && (sfrReq.page == CROSSBAR_CONFIG_TWO_PAGE);
	assign port0Hit = (sfrReq.addr == PORT0_PIN_DATA_ADDR);
	assign globalEn = crossbarConfigTwo_r[CFG2_GLOBAL_ENABLE];
	assign weakPullupOff = crossbarConfigTwo_r[CFG2_WEAK_PULLUP_OFF];

	// Configuration register two; unused and reserved bits stay zero.
	// Masking on the way in keeps the read-back honest and stops a
	// write of ones to reserved bits from enabling anything later
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			crossbarConfigTwo_r <= CROSSBAR_CONFIG_TWO_RESET;
		end else if (sfrReq.wr && cfg2Hit) begin
			crossbarConfigTwo_r <= sfrReq.wdata & CROSSBAR_CONFIG_TWO_MASK;
		end
	end

	// Port 0 output latch. It only reaches a pad that no enabled
	// peripheral has claimed, so a write never fights a peripheral;
	// it comes out of reset high, matching the idle pin level
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			port0Latch_r <= PORT0_PIN_DATA_RESET;
		end else if (sfrReq.wr && port0Hit) begin
			// Any page reaches the latch
			port0Latch_r <= sfrReq.wdata;
		end
	end

	// Read data: port 0 reads the pins, not the latch. A pad held low
	// from outside reads 0 even when the latch holds 1, which is how
	// software sees the real level. The value stands until the next read.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sfrRdata <= '0;
		end else if (sfrReq.rd) begin
			// Only a read strobe moves the data; between reads it holds
			if (port0Hit) begin
				sfrRdata <= pinSync[PORT_WIDTH-1:0];
			end else if (cfg2Hit) begin
				sfrRdata <= crossbarConfigTwo_r;
			end else begin
				// Unmapped addresses read as zero
				sfrRdata <= '0;
			end
		end
	end

	// Slot requests in fixed priority order. Each slot is one signal
	// that needs one pin; a peripheral with several signals owns a run
	// of neighbouring slots, so its pins always come out together.
	// A cleared enable bit leaves its slots at zero and so costs no pin.
	always_comb begin
		// Start with every slot idle
		slotEn = '0;
		slotEn[SLOT_TX0] = crossbarConfigZero[CFG0_FIRST_SERIAL];
		slotEn[SLOT_RX0] = crossbarConfigZero[CFG0_FIRST_SERIAL];
		slotEn[SLOT_SPI +: SPI_PINS] = {SPI_PINS{crossbarConfigZero[CFG0_SPI]}};
		slotEn[SLOT_SMB +: SMB_PINS] = {SMB_PINS{crossbarConfigZero[CFG0_SMBUS]}};
		slotEn[SLOT_TX1] = crossbarConfigTwo_r[CFG2_SECOND_SERIAL];
		slotEn[SLOT_RX1] = crossbarConfigTwo_r[CFG2_SECOND_SERIAL];
		slotEn[SLOT_CEX +: PCA_MAX] = thermo(crossbarConfigZero[CFG0_PCA_MSB:CFG0_PCA_LSB]);
		slotEn[SLOT_ECI] = crossbarConfigZero[CFG0_ECI];
		slotEn[SLOT_CP0] = crossbarConfigZero[CFG0_CP0];
		slotEn[SLOT_CP1] = crossbarConfigOne[CFG1_CP1];
		slotEn[SLOT_CP2] = crossbarConfigThree[CFG3_CP2];
		slotEn[SLOT_T0] = crossbarConfigOne[CFG1_T0];
		slotEn[SLOT_INT0] = crossbarConfigOne[CFG1_INT0];
		slotEn[SLOT_T1] = crossbarConfigOne[CFG1_T1];
		slotEn[SLOT_INT1] = crossbarConfigOne[CFG1_INT1];
		slotEn[SLOT_T2] = crossbarConfigOne[CFG1_T2];
		slotEn[SLOT_T2EX] = crossbarConfigOne[CFG1_T2EX];
		slotEn[SLOT_T3] = crossbarConfigThree[CFG3_T3];
		slotEn[SLOT_T3EX] = crossbarConfigThree[CFG3_T3EX];
		slotEn[SLOT_T4] = crossbarConfigTwo_r[CFG2_TIMER4_COUNT];
		slotEn[SLOT_TIMER4_CAPTURE_INPUT] = crossbarConfigTwo_r[CFG2_TIMER4_CAPTURE];
		slotEn[SLOT_SYSCLK] = crossbarConfigOne[CFG1_SYSCLK];
		slotEn[SLOT_CONV_START] = crossbarConfigThree[CFG3_CONV_START];
	end

	// Each slot takes the next free pin after all higher-priority slots.
	// The running count is a prefix sum over the enables: slot s lands on
	// the number of enabled slots ahead of it. The first serial port sits
	// in slots 0 and 1, so when enabled it always lands on pins 0 and 1.
	always_comb begin
		logic [IDX_W-1:0] next;
		// Count of enabled slots so far
		next = '0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			slotPin[s] = next;
			next = next + IDX_W'(slotEn[s]);
		end
	end

	// Pin drive and peripheral input selection. Later assignments win,
	// so the order below is the precedence: latch first, then any
	// peripheral that claims the pin, then the global enable on top.
	// A slot whose index lies past the last pin matches no pin and
	// is left without one, which covers the smaller package.
	always_comb begin
		// Defaults: pads undriven, peripherals see an idle high level
		pinOut_nxt = '0;
		pinOe_nxt = '0;
		periphIn_nxt = '1;
		// Unclaimed port 0 pins follow the latch; pins of the other
		// ports have no latch here and stay undriven unless claimed
		for (int p = 0; p < PORT_WIDTH; p++) begin
			pinOut_nxt[p] = port0Latch_r[p];
			pinOe_nxt[p] = 1'b1;
		end
		// Claimed pins go to their peripheral; a peripheral with its drive
		// low leaves the pad as an input even on a claimed pin, and its
		// input slot always sees the synchronised level of that pin
		for (int s = 0; s < NUM_SLOTS; s++) begin
			for (int p = 0; p < NUM_PINS; p++) begin
				if (slotEn[s] && (32'(slotPin[s]) == p)) begin
					pinOut_nxt[p] = periphOut[s];
					pinOe_nxt[p] = periphDrive[s];
					periphIn_nxt[s] = pinSync[p];
				end
			end
		end
		// Crossbar off: every pin is an input, and every peripheral
		// sees an idle high level rather than whatever the pads show
		if (!globalEn) begin
			pinOe_nxt = '0;
			periphIn_nxt = '1;
		end
	end

	// Registered pin and peripheral outputs. Registering costs one cycle
	// of latency but keeps the priority chain off the pad timing, and
	// reset leaves every pad undriven with every peripheral input high.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pinOut <= '1;
			pinOe <= '0;
			periphIn <= '1;
			periphPinned <= '0;
		end else begin
			pinOut <= pinOut_nxt;
			pinOe <= pinOe_nxt;
			periphIn <= periphIn_nxt;
			// A slot counts as pinned only while the crossbar is on and its index fits
			for (int s = 0; s < NUM_SLOTS; s++) begin
				periphPinned[s] <= globalEn && slotEn[s] && (32'(slotPin[s]) < NUM_PINS);
			end
		end
	end
endmodule

//--- logic/pxb_pkg.sv
// Package holding the crossbar constants, register map and bus carrier types
// Operation
// - Ports zero to three routed by fixed priority
// - Pins assigned upward from port 0 pin 0
// - First UART highest, conversion start lowest
// - Only enabled peripherals take pins
// - First UART always on pins 0 and 1
// - Global enable off forces all pins input
// - Timer4 count input routed only when enabled
// - Port 0 read returns actual pin levels
package pxb_pkg;
	// Register addresses and pages
	localparam logic [7:0] PORT0_PIN_DATA_ADDR = 8'h80;
	localparam logic [7:0] CROSSBAR_CONFIG_TWO_ADDR = 8'he3;
	localparam logic [7:0] CROSSBAR_CONFIG_TWO_PAGE = 8'h0f;
	// Reset values
	localparam logic [7:0] PORT0_PIN_DATA_RESET = 8'hff;
	localparam logic [7:0] CROSSBAR_CONFIG_TWO_RESET = 8'h00;
	// Writable bits of configuration register two; others read zero
	localparam logic [7:0] CROSSBAR_CONFIG_TWO_MASK = 8'hdc;
	// Bit positions in configuration register two
	localparam int CFG2_WEAK_PULLUP_OFF = 7;
	localparam int CFG2_GLOBAL_ENABLE = 6;
	localparam int CFG2_TIMER4_CAPTURE = 4;
	localparam int CFG2_TIMER4_COUNT = 3;
	localparam int CFG2_SECOND_SERIAL = 2;
	// Bit positions in configuration register zero
	localparam int CFG0_SMBUS = 0;
	localparam int CFG0_SPI = 1;
	localparam int CFG0_FIRST_SERIAL = 2;
	localparam int CFG0_PCA_LSB = 3;
	localparam int CFG0_PCA_MSB = 5;
	localparam int CFG0_ECI = 6;
	localparam int CFG0_CP0 = 7;
	// Bit positions in configuration register one
	localparam int CFG1_CP1 = 0;
	localparam int CFG1_T0 = 1;
	localparam int CFG1_INT0 = 2;
	localparam int CFG1_T1 = 3;
	localparam int CFG1_INT1 = 4;
	localparam int CFG1_T2 = 5;
	localparam int CFG1_T2EX = 6;
	localparam int CFG1_SYSCLK = 7;
	// Bit positions in configuration register three
	localparam int CFG3_T3 = 0;
	localparam int CFG3_T3EX = 1;
	localparam int CFG3_CONV_START = 2;
	localparam int CFG3_CP2 = 3;
	// Peripheral signal slots in priority order, highest first
	localparam int SLOT_TX0 = 0;
	localparam int SLOT_RX0 = 1;
	localparam int SLOT_SPI = 2;
	localparam int SLOT_SMB = 6;
	localparam int SLOT_TX1 = 8;
	localparam int SLOT_RX1 = 9;
	localparam int SLOT_CEX = 10;
	localparam int SLOT_ECI = 16;
	localparam int SLOT_CP0 = 17;
	localparam int SLOT_CP1 = 18;
	localparam int SLOT_CP2 = 19;
	localparam int SLOT_T0 = 20;
	localparam int SLOT_INT0 = 21;
	localparam int SLOT_T1 = 22;
	localparam int SLOT_INT1 = 23;
	localparam int SLOT_T2 = 24;
	localparam int SLOT_T2EX = 25;
	localparam int SLOT_T3 = 26;
	localparam int SLOT_T3EX = 27;
	localparam int SLOT_T4 = 28;
	localparam int SLOT_TIMER4_CAPTURE_INPUT = 29;
	localparam int SLOT_SYSCLK = 30;
	localparam int SLOT_CONV_START = 31;
	localparam int NUM_SLOTS = 32;
	localparam int SPI_PINS = 4;
	localparam int SMB_PINS = 2;
	localparam int PCA_MAX = 6;
	// Pin counts for the two package sizes
	localparam int PINS_LARGE = 32;
	localparam int PINS_SMALL = 24;
	localparam int PORT_WIDTH = 8;
	// Special function register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] page;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} pxb_sfr_req_type;
endpackage

//--- logic/pxb_pin_sync.sv
// Two-stage synchroniser for the external pin levels
`timescale 1ns/10ps
module pxb_pin_sync import pxb_pkg::*; #(
	parameter int WIDTH = PINS_LARGE
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_r; // First stage, read only by the second

	// Two flops in series; reset to all high, the idle pin level
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stage1_r <= '1;
			syncOut <= '1;
		end else begin
			stage1_r <= asyncIn;
			syncOut <= stage1_r;
		end
	end
endmodule

//--- test/pxb_crossbar_props.sv
// Port checker for the priority crossbar
`timescale 1ns/10ps
module pxb_crossbar_props import pxb_pkg::*; #(
	parameter int NUM_PINS = PINS_LARGE
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register bus
	input wire pxb_sfr_req_type sfrReq,
	input wire logic [7:0] sfrRdata,
	// Routing
	input wire logic [7:0] crossbarConfigZero,
	input wire logic [NUM_SLOTS-1:0] periphOut,
	input wire logic [NUM_SLOTS-1:0] periphIn,
	input wire logic [NUM_SLOTS-1:0] periphPinned,
	input wire logic [NUM_PINS-1:0] pinIn,
	input wire logic [NUM_PINS-1:0] pinOut,
	input wire logic [NUM_PINS-1:0] pinOe
);
	logic [7:0] cfgTwo_r; // Shadow of configuration register two
	logic cfgHit; // Request addresses register two
	logic p0Rd; // Read of the port 0 register
	assign cfgHit = sfrReq.addr == CROSSBAR_CONFIG_TWO_ADDR && sfrReq.page == CROSSBAR_CONFIG_TWO_PAGE;
	assign p0Rd = sfrReq.rd && sfrReq.addr == PORT0_PIN_DATA_ADDR;
	// Follow writes so routing can be predicted
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfgTwo_r <= CROSSBAR_CONFIG_TWO_RESET;
		end else if (sfrReq.wr && cfgHit) begin
			cfgTwo_r <= sfrReq.wdata & CROSSBAR_CONFIG_TWO_MASK;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Pins held long enough to pass the synchroniser, then read
	sequence pinsStill; $stable(pinIn[7:0])[*4]; endsequence
	sequence portRead; pinsStill ##0 p0Rd; endsequence
	a_off_no_drive: assert property (!cfgTwo_r[CFG2_GLOBAL_ENABLE] |=> pinOe == '0)
		else $error("pin driven while crossbar off");
	a_off_inputs_high: assert property (!cfgTwo_r[CFG2_GLOBAL_ENABLE] |=> periphIn == '1 && periphPinned == '0)
		else $error("peripheral pinned while crossbar off");
	a_first_serial_pins: assert property (cfgTwo_r[CFG2_GLOBAL_ENABLE] && crossbarConfigZero[CFG0_FIRST_SERIAL]
		|=> periphPinned[SLOT_TX0] && periphPinned[SLOT_RX0] && pinOut[0] == $past(periphOut[SLOT_TX0]))
		else $error("first serial port not on pins 0 and 1");
	a_disabled_no_pin: assert property (!crossbarConfigZero[CFG0_FIRST_SERIAL] |=> !periphPinned[SLOT_TX0])
		else $error("disabled serial port holds a pin");
	a_count_route: assert property (!cfgTwo_r[CFG2_TIMER4_COUNT] |=> !periphPinned[SLOT_T4])
		else $error("timer4 count input routed while off");
	a_capture_route: assert property (!cfgTwo_r[CFG2_TIMER4_CAPTURE] |=> !periphPinned[SLOT_TIMER4_CAPTURE_INPUT])
		else $error("timer4 capture input routed while off");
	a_second_serial: assert property (cfgTwo_r[CFG2_GLOBAL_ENABLE] && cfgTwo_r[CFG2_SECOND_SERIAL]
		&& crossbarConfigZero == 8'h00 |=> periphPinned[SLOT_TX1] && periphPinned[SLOT_RX1])
		else $error("second serial port not routed");
	a_port_read: assert property (portRead |=> sfrRdata == $past(pinIn[7:0]))
		else $error("port 0 read differs from pin levels");
endmodule
bind pxb_crossbar pxb_crossbar_props #(.NUM_PINS(NUM_PINS)) i_pxb_crossbar_props (.sys_clk, .reset, .sfrReq,
	.sfrRdata, .crossbarConfigZero, .periphOut, .periphIn, .periphPinned, .pinIn, .pinOut, .pinOe);

//--- test/pxb_pad_model.sv
// Pads outside the crossbar: outside level unless the block drives
`timescale 1ns/10ps
module pxb_pad_model import pxb_pkg::*; #(
	parameter int NUM_PINS = PINS_LARGE
) (
	// Block side
	input wire logic [NUM_PINS-1:0] pinOut,
	input wire logic [NUM_PINS-1:0] pinOe,
	// Outside level and resulting pad level
	input wire logic [NUM_PINS-1:0] extLevel,
	output logic [NUM_PINS-1:0] pinIn
);
	// A driven pad shows the block, an idle pad the outside world
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pinIn[i] = pinOe[i] ? pinOut[i] : extLevel[i];
		end
	end
endmodule

//--- test/tb_pxb_crossbar.sv
// Bench for the priority crossbar
`timescale 1ns/10ps
module tb_pxb_crossbar import pxb_pkg::*;;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	pxb_sfr_req_type req = '0;
	logic [7:0] rdata;
	logic [7:0] cfg0 = 8'h00; // Configuration registers held outside the block
	logic [7:0] cfg1 = 8'h00;
	logic [7:0] cfg3 = 8'h00;
	logic pullOff; // Pull-up disable output
	logic [31:0] pOut = '0;
	logic [31:0] pDrv = '0;
	logic [31:0] ext = 32'hffff_ff3c;
	logic [31:0] pIn, pPin, pinIn, pinOut, pinOe;
	int error_cnt = 0;
	int num_checks = 0;
	always #50 sys_clk = ~sys_clk;
	// Design and its pads
	pxb_crossbar #(.NUM_PINS(32)) i_pxb_crossbar (.sys_clk, .reset, .sfrReq(req), .sfrRdata(rdata),
		.crossbarConfigZero(cfg0), .crossbarConfigOne(cfg1), .crossbarConfigThree(cfg3), .periphOut(pOut),
		.periphDrive(pDrv), .periphIn(pIn), .periphPinned(pPin), .pinIn, .pinOut, .pinOe, .weakPullupOff(pullOff));
	pxb_pad_model #(.NUM_PINS(32)) i_pxb_pad_model (.pinOut, .pinOe, .extLevel(ext), .pinIn);
	task chk(input logic [31:0] exp, input logic [31:0] got, input string what);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		@(posedge sys_clk);
		#1 req = '{a, p, 1'b1, 1'b0, d};
		@(posedge sys_clk);
		#1 req.wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp, input string what);
		@(posedge sys_clk);
		#1 req = '{a, p, 1'b0, 1'b1, 8'h00};
		@(posedge sys_clk);
		#1 req.rd = 1'b0;
		@(posedge sys_clk);
		#1 chk(32'(exp), 32'(rdata), what);
	endtask
	task settle;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	// Reset state, pins free
	task t_reset;
		chk(32'h0, pinOe, "oe");
		chk(32'h0, pPin, "pinned");
		chk(32'h0, 32'(pullOff), "pulloff");
		rd(8'he3, 8'h0f, 8'h00, "cfg2");
		rd(8'h80, 8'h00, 8'h3c, "p0");
	endtask
	// Latch drives unclaimed port 0 pins
	task t_latch;
		wr(8'h80, 8'h00, 8'h5a);
		wr(8'he3, 8'h0f, 8'h40);
		settle();
		chk(32'h0000_00ff, pinOe, "oe");
		chk(32'h5a, 32'(pinOut[7:0]), "out");
		rd(8'h80, 8'h03, 8'h5a, "p0");
	endtask
	// Priority order with every register two route
	task t_route;
		pDrv = 32'h0000_0101;
		pOut = 32'h0000_0100;
		wr(8'he3, 8'h0f, 8'hff);
		rd(8'he3, 8'h0f, 8'hdc, "cfg2");
		settle();
		chk(32'h1, 32'(pullOff), "pulloff");
		chk(32'h3000_0300, pPin, "pinned");
		chk(32'hf1, 32'(pinOe[7:0]), "oe");
		cfg0 = 8'h04;
		settle();
		chk(32'h3000_0303, pPin, "pinned");
		chk(32'hc5, 32'(pinOe[7:0]), "oe");
		chk(32'h6, 32'({pinOut[7:6], pinOut[2], pinOut[0]}), "out");
		chk(32'h5, 32'({pIn[SLOT_RX1], pIn[SLOT_RX0], pIn[SLOT_SPI]}), "in");
	endtask
	// Lowest-priority slots from registers one and three close the run on pin 7
	task t_order;
		pDrv = 32'h4000_0101;
		cfg1 = 8'h80;
		cfg3 = 8'h04;
		settle();
		chk(32'hf000_0303, pPin, "pinned");
		chk(32'h45, 32'(pinOe[7:0]), "oe");
		chk(32'h0, 32'(pinOut[6]), "out");
		chk(32'h0, 32'(pIn[SLOT_CONV_START]), "in");
	endtask
	// Crossbar off, stray accesses
	task t_off;
		wr(8'he3, 8'h00, 8'h40);
		rd(8'he3, 8'h0f, 8'hdc, "cfg2");
		wr(8'he3, 8'h0f, 8'h00);
		settle();
		chk(32'h0, pinOe, "oe");
		chk(32'hffff_ffff, pIn, "in");
		chk(32'h0, pPin, "pinned");
		rd(8'h80, 8'h00, 8'h3c, "p0");
		rd(8'he3, 8'h0f, 8'h00, "cfg2");
		rd(8'h90, 8'h00, 8'h00, "unmapped");
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Cut a hang short
	initial begin
		#2000000;
		error_cnt++;
		results();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 reset = 1'b0;
		t_reset();
		t_latch();
		t_route();
		t_order();
		t_off();
		results();
	end
endmodule
